// *** rtl/csr_pkg.sv ***
`default_nettype none
package csr_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INDIRECT_PORT_0 = 8'h00;
  localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_PORT_1 = 8'h02;
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
  localparam logic [7:0] ADDR_WORKING_REGISTER = 8'h05;
  localparam logic [7:0] ADDR_PROG_COUNTER_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h07;
  localparam logic [7:0] ADDR_TABLE_DATA_HIGH = 8'h08;
  localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h09;
  localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h0a;
  // Special area limit and the unused window of bank 1
  localparam logic [7:0] ADDR_SPECIAL_LAST = 8'h7f;
  localparam logic [7:0] ADDR_UNUSED_FIRST = 8'h60;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_SLEEP = 4;
  localparam int FLAG_WATCHDOG = 5;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h0f;
  localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] GP_FIRST = 8'h80;
  localparam int BANK_BITS = 2;
  localparam int BANKS = 4;
  localparam int GP_WORDS = 128;
  localparam int PC_BITS = 13;
  localparam int PROG_BITS = 16;
  localparam logic [1:0] DUMMY_CYCLES = 2'h1;

  // ALU operation selects
  typedef enum logic [2:0] {
    CSR_ALU_NONE = 3'b000,
    CSR_ALU_ADD = 3'b001,
    CSR_ALU_SUB = 3'b010,
    CSR_ALU_LOGIC = 3'b011,
    CSR_ALU_RLC = 3'b100,
    CSR_ALU_RRC = 3'b101
  } csr_alu_t;

  // System events from the core
  typedef enum logic [1:0] {
    CSR_EV_NONE = 2'b00,
    CSR_EV_WDT_REFRESH = 2'b01,
    CSR_EV_HALT = 2'b10,
    CSR_EV_WDT_TIMEOUT = 2'b11
  } csr_event_t;

  // Data-memory access request from the execution core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_mem_req_t;

  // ALU request
  typedef struct packed {
    csr_alu_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic to_acc;
  } csr_alu_req_t;

  // Whole module state apart from the banked general memory
  typedef struct packed {
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [BANK_BITS-1:0] bank;
    logic [7:0] acc;
    logic [PC_BITS-1:0] pc;
    logic [7:0] tbl_lo;
    logic [7:0] tbl_hi;
    logic [7:0] tbl_data_hi;
    logic [5:0] flags;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] dummy;
    logic stall;
    logic [7:0] tbl_lo_result;
  } csr_state_t;
endpackage
`default_nettype wire

// *** rtl/csr_core_regs.sv ***
`default_nettype none
// Summary of operation
// - Indirect ports redirect to paired pointer address
// - Pair zero bank 0; pair one any bank
// - Indirect access to ports: read zero, write ignored
// - Pointer registers are real read-write storage
// - Direct addressing always hits bank 0
// - Bank field decodes to banks 0 through 3
// - Unimplemented bank select bits read zero
// - Reset clears bank, except sleeping watchdog reset
// - Special registers visible from every bank
// - Bank 1 special 60H-7FH reads zero
// - Register moves pass through working register
// - Low byte write jumps within current page
// - Low byte jump inserts one dummy cycle
// - Table read: high to register, low out
// - Status writes leave watchdog and sleep flags
// - Carry from add, no-borrow, or rotate
// - Half carry from nibble carry or no-borrow
// - Zero flag set on zero result
// - Wrap flag on carry-in differing carry-out
// - Sleep flag: clear power-up/refresh, set halt
// - Watchdog flag: clear power-up/refresh/halt, set timeout
// - Status never saved on stack automatically
module csr_core_regs (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic POWER_UP,
  input wire logic SLEEPING,
  // Data-memory access
  input wire csr_pkg::csr_mem_req_t MEM_REQ,
  output logic [7:0] MEM_RDATA,
  output logic MEM_RVALID,
  // Working register and ALU
  input wire csr_pkg::csr_alu_req_t ALU_REQ,
  output logic [7:0] ACC_OUT,
  // Program counter
  input wire logic PC_ADVANCE,
  output logic [csr_pkg::PC_BITS-1:0] PC_OUT,
  output logic STALL,
  // Table read
  input wire logic TABLE_READ,
  input wire logic [csr_pkg::PROG_BITS-1:0] PROG_WORD,
  output logic [15:0] TABLE_ADDR,
  output logic [7:0] TABLE_LOW_BYTE,
  // System events and flags
  input wire csr_pkg::csr_event_t SYS_EVENT,
  output logic [7:0] STATUS_OUT,
  output logic [csr_pkg::BANK_BITS-1:0] BANK_OUT
);
  import csr_pkg::*;

  csr_state_t s_reg;
  csr_state_t s_next;
  // Storage: banked general memory above the special area
  logic [7:0] gp_mem_reg [BANKS][GP_WORDS];

  // ---------------------------------------------------------------
  // Address resolution
  // ---------------------------------------------------------------
  logic is_ind0;
  logic is_ind1;
  logic [7:0] eff_addr;
  logic [BANK_BITS-1:0] eff_bank;
  logic ind_to_port;
  logic gp_hit;
  logic [6:0] gp_idx;
  // Ports resolve through their pointer; direct goes to bank 0
  always_comb begin
    is_ind0 = (MEM_REQ.addr == ADDR_INDIRECT_PORT_0);
    is_ind1 = (MEM_REQ.addr == ADDR_INDIRECT_PORT_1);
    eff_addr = MEM_REQ.addr;
    eff_bank = '0;
    if (is_ind0) begin
      eff_addr = s_reg.ptr0;
      eff_bank = '0;
    end else if (is_ind1) begin
      eff_addr = s_reg.ptr1;
      eff_bank = s_reg.bank;
    end
    ind_to_port = (is_ind0 || is_ind1) &&
                  (eff_addr == ADDR_INDIRECT_PORT_0 || eff_addr == ADDR_INDIRECT_PORT_1);
    gp_hit = (eff_addr >= GP_FIRST);
    gp_idx = eff_addr[6:0];
  end

  // ---------------------------------------------------------------
  // ALU flag generation
  // ---------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [7:0] res;
  logic c_out;
  logic h_out;
  logic c_in7;
  logic [7:0] b_eff;
  logic cin;
  // Subtract is add of inverse plus one: carry then means no borrow
  always_comb begin
    b_eff = (ALU_REQ.op == CSR_ALU_SUB) ? ~ALU_REQ.b : ALU_REQ.b;
    cin = (ALU_REQ.op == CSR_ALU_SUB);
    sum = {1'b0, ALU_REQ.a} + {1'b0, b_eff} + {8'h00, cin};
    nib = {1'b0, ALU_REQ.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    low7 = {1'b0, ALU_REQ.a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
    c_out = sum[8];
    h_out = nib[4];
    c_in7 = low7[7];
    res = sum[7:0];
    if (ALU_REQ.op == CSR_ALU_LOGIC) begin
      res = ALU_REQ.a;
    end else if (ALU_REQ.op == CSR_ALU_RLC) begin
      res = {ALU_REQ.a[6:0], s_reg.flags[FLAG_CARRY]};
    end else if (ALU_REQ.op == CSR_ALU_RRC) begin
      res = {s_reg.flags[FLAG_CARRY], ALU_REQ.a[7:1]};
    end
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic [7:0] rd;
  logic [7:0] status_view;
  logic jump;
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = MEM_REQ.rd;
    status_view = {2'b00, s_reg.flags};
    rd = READ_ZERO;
    jump = 1'b0;
    // Read mux; the special area is the same for every bank
    if (ind_to_port) begin
      rd = READ_ZERO;
    end else if (gp_hit) begin
      rd = gp_mem_reg[eff_bank][gp_idx];
    end else if (eff_addr >= ADDR_UNUSED_FIRST) begin
      rd = READ_ZERO;
    end else if (eff_addr == ADDR_POINTER_ZERO) begin
      rd = s_reg.ptr0;
    end else if (eff_addr == ADDR_POINTER_ONE) begin
      rd = s_reg.ptr1;
    end else if (eff_addr == ADDR_BANK_SELECT) begin
      rd = {{(8 - BANK_BITS){1'b0}}, s_reg.bank};
    end else if (eff_addr == ADDR_WORKING_REGISTER) begin
      rd = s_reg.acc;
    end else if (eff_addr == ADDR_PROG_COUNTER_LOW) begin
      rd = s_reg.pc[7:0];
    end else if (eff_addr == ADDR_TABLE_POINTER_LOW) begin
      rd = s_reg.tbl_lo;
    end else if (eff_addr == ADDR_TABLE_DATA_HIGH) begin
      rd = s_reg.tbl_data_hi;
    end else if (eff_addr == ADDR_TABLE_POINTER_HIGH) begin
      rd = s_reg.tbl_hi;
    end else if (eff_addr == ADDR_STATUS_FLAGS) begin
      rd = status_view;
    end
    if (MEM_REQ.rd) begin
      s_next.rdata = rd;
    end
    // Program counter advance and dummy-cycle stall
    if (s_reg.dummy != 2'h0) begin
      s_next.dummy = s_reg.dummy - 2'h1;
    end else if (PC_ADVANCE) begin
      s_next.pc = s_reg.pc + 13'h0001;
    end
    // ALU results land only in the working register
    if (ALU_REQ.op != CSR_ALU_NONE) begin
      if (ALU_REQ.to_acc) begin
        s_next.acc = res;
      end
      s_next.flags[FLAG_ZERO] = (res == 8'h00);
      if (ALU_REQ.op == CSR_ALU_ADD || ALU_REQ.op == CSR_ALU_SUB) begin
        s_next.flags[FLAG_CARRY] = c_out;
        s_next.flags[FLAG_HALF] = h_out;
        s_next.flags[FLAG_WRAP] = c_in7 ^ c_out;
      end else if (ALU_REQ.op == CSR_ALU_RLC) begin
        s_next.flags[FLAG_CARRY] = ALU_REQ.a[7];
      end else if (ALU_REQ.op == CSR_ALU_RRC) begin
        s_next.flags[FLAG_CARRY] = ALU_REQ.a[0];
      end
    end
    // Register writes; a port-to-port indirect write does nothing
    if (MEM_REQ.wr && !ind_to_port && !gp_hit) begin
      if (eff_addr == ADDR_POINTER_ZERO) begin
        s_next.ptr0 = MEM_REQ.wdata;
      end else if (eff_addr == ADDR_POINTER_ONE) begin
        s_next.ptr1 = MEM_REQ.wdata;
      end else if (eff_addr == ADDR_BANK_SELECT) begin
        s_next.bank = MEM_REQ.wdata[BANK_BITS-1:0];
      end else if (eff_addr == ADDR_WORKING_REGISTER) begin
        s_next.acc = MEM_REQ.wdata;
      end else if (eff_addr == ADDR_PROG_COUNTER_LOW) begin
        s_next.pc = {s_reg.pc[PC_BITS-1:8], MEM_REQ.wdata};
        jump = 1'b1;
      end else if (eff_addr == ADDR_TABLE_POINTER_LOW) begin
        s_next.tbl_lo = MEM_REQ.wdata;
      end else if (eff_addr == ADDR_TABLE_DATA_HIGH) begin
        s_next.tbl_data_hi = MEM_REQ.wdata;
      end else if (eff_addr == ADDR_TABLE_POINTER_HIGH) begin
        s_next.tbl_hi = MEM_REQ.wdata;
      end else if (eff_addr == ADDR_STATUS_FLAGS) begin
        s_next.flags[3:0] = MEM_REQ.wdata[3:0] & STATUS_WRITE_MASK[3:0];
      end
    end
    if (jump) begin
      s_next.dummy = DUMMY_CYCLES;
    end
    s_next.stall = jump || (s_reg.dummy > 2'h1);
    // Table read: high byte kept here, low byte handed out
    if (TABLE_READ) begin
      s_next.tbl_data_hi = PROG_WORD[15:8];
      s_next.tbl_lo_result = PROG_WORD[7:0];
    end
    // System events own the top two flags
    if (SYS_EVENT == CSR_EV_WDT_REFRESH) begin
      s_next.flags[FLAG_SLEEP] = 1'b0;
      s_next.flags[FLAG_WATCHDOG] = 1'b0;
    end else if (SYS_EVENT == CSR_EV_HALT) begin
      s_next.flags[FLAG_SLEEP] = 1'b1;
      s_next.flags[FLAG_WATCHDOG] = 1'b0;
    end else if (SYS_EVENT == CSR_EV_WDT_TIMEOUT) begin
      s_next.flags[FLAG_WATCHDOG] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  // Status lives only here; nothing pushes it on calls or interrupts
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_reg <= '0;
      s_reg.bank <= BANK_SELECT_RESET[BANK_BITS-1:0];
      // Only power-up clears the flags; other resets keep them, except a timeout sets the watchdog flag
      if (!POWER_UP) begin
        s_reg.flags <= s_reg.flags;
        if (SYS_EVENT == CSR_EV_WDT_TIMEOUT) begin
          s_reg.flags[FLAG_WATCHDOG] <= 1'b1;
          // A watchdog wake from sleep keeps the selected bank
          if (SLEEPING) begin
            s_reg.bank <= s_reg.bank;
          end
        end
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // General memory write, per bank
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      always_ff @(posedge SYS_CLK) begin
        if (MEM_REQ.wr && !ind_to_port && gp_hit && eff_bank == BANK_BITS'(gb)) begin
          gp_mem_reg[gb][gp_idx] <= MEM_REQ.wdata;
        end
      end
    end
  endgenerate

  // Outputs straight from state flops
  assign MEM_RDATA = s_reg.rdata;
  assign MEM_RVALID = s_reg.rvalid;
  assign ACC_OUT = s_reg.acc;
  assign PC_OUT = s_reg.pc;
  assign STALL = s_reg.stall;
  assign TABLE_ADDR = {s_reg.tbl_hi, s_reg.tbl_lo};
  assign TABLE_LOW_BYTE = s_reg.tbl_lo_result;
  assign STATUS_OUT = {2'b00, s_reg.flags};
  assign BANK_OUT = s_reg.bank;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_port_self_read;
    @(posedge SYS_CLK) disable iff (RESET) (MEM_REQ.rd && ind_to_port) |=> (MEM_RDATA == 8'h00);
  endproperty
  a_port_self_read: assert property (p_port_self_read) else $error("port self read not zero");

  property p_unused_zero;
    @(posedge SYS_CLK) disable iff (RESET)
      (MEM_REQ.rd && !is_ind0 && !is_ind1 && MEM_REQ.addr >= ADDR_UNUSED_FIRST && MEM_REQ.addr < GP_FIRST)
      |=> (MEM_RDATA == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused area not zero");

  property p_bank_upper;
    @(posedge SYS_CLK) disable iff (RESET)
      (MEM_REQ.rd && !is_ind0 && !is_ind1 && MEM_REQ.addr == ADDR_BANK_SELECT) |=> (MEM_RDATA[7:2] == 6'h00);
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper bits set");

  sequence s_pcl_write;
    MEM_REQ.wr && !is_ind0 && !is_ind1 && MEM_REQ.addr == ADDR_PROG_COUNTER_LOW;
  endsequence
  property p_pcl_page;
    @(posedge SYS_CLK) disable iff (RESET)
      s_pcl_write |=> (PC_OUT[PC_BITS-1:8] == $past(PC_OUT[PC_BITS-1:8])) && (PC_OUT[7:0] == $past(MEM_REQ.wdata));
  endproperty
  a_pcl_page: assert property (p_pcl_page) else $error("page changed on low byte write");

  property p_dummy;
    @(posedge SYS_CLK) disable iff (RESET) s_pcl_write |=> STALL;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy cycle after jump");

  property p_status_write;
    @(posedge SYS_CLK) disable iff (RESET)
      (MEM_REQ.wr && !is_ind0 && !is_ind1 && MEM_REQ.addr == ADDR_STATUS_FLAGS && SYS_EVENT == CSR_EV_NONE)
      |=> (STATUS_OUT[5:4] == $past(STATUS_OUT[5:4]));
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write hit system flags");

  property p_halt;
    @(posedge SYS_CLK) disable iff (RESET)
      (SYS_EVENT == CSR_EV_HALT) |=> (STATUS_OUT[5:4] == 2'b01);
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");

  property p_timeout;
    @(posedge SYS_CLK) disable iff (RESET) (SYS_EVENT == CSR_EV_WDT_TIMEOUT) |=> STATUS_OUT[5];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag not set");

  property p_zero;
    @(posedge SYS_CLK) disable iff (RESET)
      (ALU_REQ.op != CSR_ALU_NONE && ALU_REQ.to_acc && !MEM_REQ.wr)
      |=> (STATUS_OUT[FLAG_ZERO] == (ACC_OUT == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag missing");

  property p_table;
    @(posedge SYS_CLK) disable iff (RESET)
      TABLE_READ |=> (TABLE_LOW_BYTE == $past(PROG_WORD[7:0]));
  endproperty
  a_table: assert property (p_table) else $error("table low byte wrong");

  // Helper: watchdog reset taken while the core sleeps
  logic wake_reset;
  assign wake_reset = RESET && !POWER_UP && SLEEPING && (SYS_EVENT == CSR_EV_WDT_TIMEOUT);

  // Dummy cycle: program counter held, stall lasts one cycle
  property p_stall_hold;
    @(posedge SYS_CLK) disable iff (RESET) (STALL && !MEM_REQ.wr) |=> (PC_OUT == $past(PC_OUT));
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("program counter moved in dummy cycle");

  property p_stall_one;
    @(posedge SYS_CLK) disable iff (RESET) (STALL && !MEM_REQ.wr) |=> !STALL;
  endproperty
  a_stall_one: assert property (p_stall_one) else $error("dummy cycle longer than one");

  property p_refresh;
    @(posedge SYS_CLK) disable iff (RESET)
      (SYS_EVENT == CSR_EV_WDT_REFRESH) |=> (STATUS_OUT[FLAG_WATCHDOG:FLAG_SLEEP] == 2'b00);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh left system flags set");

  // Reset checks stay live while reset is high, on purpose
  property p_reset_keep;
    @(posedge SYS_CLK) (RESET && !POWER_UP) |=> (STATUS_OUT[FLAG_SLEEP] == $past(STATUS_OUT[FLAG_SLEEP]));
  endproperty
  a_reset_keep: assert property (p_reset_keep) else $error("plain reset changed sleep flag");

  property p_reset_bank;
    @(posedge SYS_CLK) (RESET && !wake_reset) |=> (BANK_OUT == BANK_SELECT_RESET[BANK_BITS-1:0]);
  endproperty
  a_reset_bank: assert property (p_reset_bank) else $error("reset left bank selected");

  property p_wake_bank;
    @(posedge SYS_CLK) wake_reset |=> (BANK_OUT == $past(BANK_OUT)) && STATUS_OUT[FLAG_WATCHDOG];
  endproperty
  a_wake_bank: assert property (p_wake_bank) else $error("sleeping watchdog reset lost bank or flag");
endmodule
`default_nettype wire

// *** sim/csr_prog_mem.sv ***
`default_nettype none
// ---------------------------------------------------------------
// Program memory seen by table reads
// ---------------------------------------------------------------
module csr_prog_mem (
  // Table address from the register block
  input wire logic [15:0] table_addr,
  // Word returned to the register block
  output logic [15:0] prog_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address-dependent content so that a swapped byte or pointer shows up
  assign prog_word = {~table_addr[7:0], table_addr[15:8] ^ 8'h5a};
endmodule
`default_nettype wire

// *** sim/csr_core_regs_tb.sv ***
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module csr_core_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csr_pkg::*;
  logic SYS_CLK, RESET, POWER_UP, SLEEPING, PC_ADVANCE, TABLE_READ, STALL, MEM_RVALID;
  csr_mem_req_t MEM_REQ;
  csr_alu_req_t ALU_REQ;
  csr_event_t SYS_EVENT;
  logic [7:0] MEM_RDATA, ACC_OUT, TABLE_LOW_BYTE, STATUS_OUT;
  logic [PC_BITS-1:0] PC_OUT;
  logic [PROG_BITS-1:0] PROG_WORD;
  logic [15:0] TABLE_ADDR;
  logic [BANK_BITS-1:0] BANK_OUT;
  int n_fail = 0;
  int check_count = 0;
  // ---------------------------------------------------------------
  // Design and program memory
  // ---------------------------------------------------------------
  csr_core_regs csr_core_regs_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .POWER_UP(POWER_UP),
    .SLEEPING(SLEEPING), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID),
    .ALU_REQ(ALU_REQ), .ACC_OUT(ACC_OUT), .PC_ADVANCE(PC_ADVANCE), .PC_OUT(PC_OUT), .STALL(STALL),
    .TABLE_READ(TABLE_READ), .PROG_WORD(PROG_WORD), .TABLE_ADDR(TABLE_ADDR),
    .TABLE_LOW_BYTE(TABLE_LOW_BYTE), .SYS_EVENT(SYS_EVENT), .STATUS_OUT(STATUS_OUT), .BANK_OUT(BANK_OUT));
  csr_prog_mem csr_prog_mem_inst (.table_addr(TABLE_ADDR), .prog_word(PROG_WORD));
  // ---------------------------------------------------------------
  // Clock and access tasks
  // ---------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // Inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge SYS_CLK);
    #1;
  endtask
  // Idle cycle after each access keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    MEM_REQ = '{1'b0, 1'b1, a, d};
    step();
    MEM_REQ = '0;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    MEM_REQ = '{1'b1, 1'b0, a, 8'h00};
    step();
    MEM_REQ = '0;
    `CHK("rvalid", 1'b1, MEM_RVALID)
    `CHK("rdata", e, MEM_RDATA)
    step();
  endtask
  task automatic ev(input csr_event_t e);
    SYS_EVENT = e;
    step();
    SYS_EVENT = CSR_EV_NONE;
    step();
  endtask
  // Flags are checked under a mask where the op leaves some undefined
  task automatic alu(input csr_alu_t op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] m, input logic [7:0] e, input logic [7:0] acc);
    ALU_REQ = '{op, a, b, 1'b1};
    step();
    ALU_REQ = '{CSR_ALU_NONE, 8'h00, 8'h00, 1'b0};
    `CHK("status", e, STATUS_OUT & m)
    `CHK("acc", acc, ACC_OUT)
    step();
  endtask
  task automatic do_reset(input logic pu, input logic sl, input csr_event_t e);
    RESET = 1'b1;
    POWER_UP = pu;
    SLEEPING = sl;
    SYS_EVENT = e;
    step();
    RESET = 1'b0;
    POWER_UP = 1'b0;
    SLEEPING = 1'b0;
    SYS_EVENT = CSR_EV_NONE;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Guard against a hung run
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    RESET = 1'b1;
    POWER_UP = 1'b1;
    SLEEPING = 1'b0;
    MEM_REQ = '0;
    ALU_REQ = '{CSR_ALU_NONE, 8'h00, 8'h00, 1'b0};
    PC_ADVANCE = 1'b0;
    TABLE_READ = 1'b0;
    SYS_EVENT = CSR_EV_NONE;
    repeat (8) step();
    RESET = 1'b0;
    POWER_UP = 1'b0;
    step();
    `CHK("bank", 2'h0, BANK_OUT)
    `CHK("status", 8'h00, STATUS_OUT)
    // Pointers, indirect access and banks
    wr(ADDR_POINTER_ZERO, 8'h90);
    rd(ADDR_POINTER_ZERO, 8'h90);
    wr(ADDR_INDIRECT_PORT_0, 8'ha5);
    rd(8'h90, 8'ha5);
    wr(ADDR_POINTER_ONE, 8'h91);
    rd(ADDR_POINTER_ONE, 8'h91);
    for (int b = 0; b < BANKS; b++) begin
      wr(ADDR_BANK_SELECT, 8'(b));
      wr(ADDR_INDIRECT_PORT_1, 8'h40 + 8'(b));
    end
    for (int b = 0; b < BANKS; b++) begin
      wr(ADDR_BANK_SELECT, 8'(b));
      `CHK("bank", 2'(b), BANK_OUT)
      rd(ADDR_INDIRECT_PORT_1, 8'h40 + 8'(b));
    end
    rd(8'h91, 8'h40);
    rd(ADDR_INDIRECT_PORT_0, 8'ha5);
    rd(ADDR_POINTER_ZERO, 8'h90);
    wr(ADDR_BANK_SELECT, 8'hff);
    rd(ADDR_BANK_SELECT, 8'h03);
    // Port reached through a pointer is not storage
    wr(ADDR_POINTER_ZERO, ADDR_INDIRECT_PORT_0);
    wr(ADDR_INDIRECT_PORT_0, 8'h77);
    rd(ADDR_INDIRECT_PORT_0, 8'h00);
    rd(ADDR_POINTER_ZERO, 8'h00);
    // Unused window of bank 1
    wr(ADDR_BANK_SELECT, 8'h01);
    rd(ADDR_UNUSED_FIRST, 8'h00);
    rd(ADDR_SPECIAL_LAST, 8'h00);
    wr(ADDR_POINTER_ONE, ADDR_UNUSED_FIRST);
    rd(ADDR_INDIRECT_PORT_1, 8'h00);
    wr(ADDR_POINTER_ONE, ADDR_BANK_SELECT);
    rd(ADDR_INDIRECT_PORT_1, 8'h01);
    // Moves through the working register
    alu(CSR_ALU_LOGIC, 8'h5a, 8'h00, 8'h04, 8'h00, 8'h5a);
    rd(ADDR_WORKING_REGISTER, 8'h5a);
    wr(ADDR_WORKING_REGISTER, 8'h3c);
    rd(ADDR_WORKING_REGISTER, 8'h3c);
    // Arithmetic flags: wrap, half, zero, carry
    alu(CSR_ALU_ADD, 8'h7f, 8'h01, 8'h0f, 8'h0a, 8'h80);
    alu(CSR_ALU_ADD, 8'hff, 8'h01, 8'h0f, 8'h07, 8'h00);
    alu(CSR_ALU_SUB, 8'h05, 8'h05, 8'h0f, 8'h07, 8'h00);
    alu(CSR_ALU_SUB, 8'h00, 8'h01, 8'h0f, 8'h00, 8'hff);
    alu(CSR_ALU_RLC, 8'h80, 8'h00, 8'h01, 8'h01, 8'h00);
    alu(CSR_ALU_RRC, 8'h01, 8'h00, 8'h01, 8'h01, 8'h80);
    // Program counter low byte: page kept, one dummy cycle
    PC_ADVANCE = 1'b1;
    repeat (260) step();
    PC_ADVANCE = 1'b0;
    `CHK("pc", 13'h0104, PC_OUT)
    MEM_REQ = '{1'b0, 1'b1, ADDR_PROG_COUNTER_LOW, 8'h10};
    step();
    MEM_REQ = '0;
    PC_ADVANCE = 1'b1;
    `CHK("pc", 13'h0110, PC_OUT)
    `CHK("stall", 1'b1, STALL)
    step();
    `CHK("stall", 1'b0, STALL)
    `CHK("pc", 13'h0110, PC_OUT)
    step();
    PC_ADVANCE = 1'b0;
    `CHK("pc", 13'h0111, PC_OUT)
    // Table read
    wr(ADDR_TABLE_POINTER_LOW, 8'h34);
    wr(ADDR_TABLE_POINTER_HIGH, 8'h12);
    `CHK("taddr", 16'h1234, TABLE_ADDR)
    TABLE_READ = 1'b1;
    step();
    TABLE_READ = 1'b0;
    `CHK("tlow", 8'h12 ^ 8'h5a, TABLE_LOW_BYTE)
    rd(ADDR_TABLE_DATA_HIGH, ~8'h34);
    // System flags against status writes
    ev(CSR_EV_HALT);
    `CHK("status", 2'b01, STATUS_OUT[5:4])
    ev(CSR_EV_WDT_TIMEOUT);
    `CHK("status", 2'b11, STATUS_OUT[5:4])
    wr(ADDR_STATUS_FLAGS, 8'hff);
    `CHK("status", 8'h3f, STATUS_OUT)
    wr(ADDR_STATUS_FLAGS, 8'h00);
    rd(ADDR_STATUS_FLAGS, 8'h30);
    ev(CSR_EV_WDT_REFRESH);
    `CHK("status", 8'h00, STATUS_OUT)
    ev(CSR_EV_HALT);
    ev(CSR_EV_WDT_TIMEOUT);
    ev(CSR_EV_HALT);
    `CHK("status", 2'b01, STATUS_OUT[5:4])
    // Watchdog reset while sleeping keeps the bank
    wr(ADDR_BANK_SELECT, 8'h02);
    do_reset(1'b0, 1'b1, CSR_EV_WDT_TIMEOUT);
    `CHK("bank", 2'h2, BANK_OUT)
    `CHK("status", 2'b11, STATUS_OUT[5:4])
    step();
    do_reset(1'b0, 1'b0, CSR_EV_NONE);
    `CHK("bank", 2'h0, BANK_OUT)
    `CHK("status", 2'b11, STATUS_OUT[5:4])
    step();
    do_reset(1'b1, 1'b0, CSR_EV_NONE);
    `CHK("status", 8'h00, STATUS_OUT)
    step();
    complete_run();
  end
endmodule
`default_nettype wire
